// file: rtl/sysctl_coproc_access_decode.sv
`timescale 1ns/100ps

module sysctl_coproc_access_decode (
    input  wire logic        i_ref_clk,      // core clock
    input  wire logic        i_rst_n,        // async bus reset, active low
    input  wire logic        i_xfer_valid,   // core offers a coprocessor instruction
    input  wire logic [31:0] i_instr,        // instruction word
    input  wire logic        i_cond_pass,    // condition field passed
    input  wire logic        i_privileged,   // core runs in a privileged mode
    input  wire logic [31:0] i_wdata,        // core register value for writes
    input  wire logic [31:0] i_tgt_rdata,    // selected register value from its owner
    input  wire logic        i_data_abort,   // memory access aborted
    input  wire logic        i_mem_access,   // aborted instruction had base writeback
    output logic             o_xfer_ready,   // decoder takes a new instruction
    output logic             o_rd_strobe,    // read of the selected register
    output logic             o_wr_strobe,    // write of the selected register
    output logic [3:0]       o_reg_num,      // selected register number
    output logic [3:0]       o_sub_sel,      // register or operation within it
    output logic [2:0]       o_opc2,         // raw second opcode field
    output logic [3:0]       o_sec_field,    // raw secondary register field
    output logic             o_side_instr,   // instruction-side copy selected
    output logic [31:0]      o_wdata,        // write data held for the owner
    output logic [31:0]      o_rd_data,      // read result to the core
    output logic             o_rd_valid,     // read result is on o_rd_data
    output logic             o_undef_trap,   // take the undefined instruction trap
    output logic             o_xfer_done,    // instruction finished
    output logic             o_base_restore  // restore base register now
);

    sysctl_pkg::xfer_state_t state_r;     // sequencer state
    sysctl_pkg::xfer_state_t state_nxt;   // its next value

    logic        for_sysctl;              // instruction is ours
    logic        is_xfer;                 // transfer kind
    logic        is_read;                 // read direction
    logic        is_data_op;              // data operation kind
    logic        is_ldst;                 // load or store kind
    logic        take;                    // instruction accepted this cycle
    logic        trap_nxt;                // trap decision for the taken word
    logic        acc_nxt;                 // access decision for the taken word
    logic        trap_r;                  // trap pending in access cycle
    logic        acc_r;                   // access pending in access cycle
    logic        read_r;                  // pending access is a read
    logic        readable;                // number defined as readable
    logic        writable;                // number defined as writable
    logic        base_restore_r;          // registered restore pulse
    logic [3:0]  prim;                    // primary field of the word
    logic [3:0]  sec;                     // secondary field of the word
    logic [2:0]  opc2;                    // second opcode field of the word
    logic [3:0]  sub_nxt;                 // decoded sub selection
    logic        side_nxt;                // decoded side selection
    logic [3:0]  reg_num_r;               // held register number
    logic [3:0]  sub_r;                   // held sub selection
    logic [2:0]  opc2_r;                  // held opcode2
    logic [3:0]  sec_r;                   // held secondary field
    logic        side_r;                  // held side
    logic [31:0] wdata_r;                 // held write data
    logic [31:0] rd_data_r;               // held read result

    // kind of the offered word
    sysctl_instr_classify u_classify (
        .i_instr      (i_instr),
        .o_for_sysctl (for_sysctl),
        .o_is_xfer    (is_xfer),
        .o_is_read    (is_read),
        .o_is_data_op (is_data_op),
        .o_is_ldst    (is_ldst)
    );

    assign prim = i_instr[sysctl_pkg::PRIM_MSB:sysctl_pkg::PRIM_LSB];
    assign sec  = i_instr[sysctl_pkg::SEC_MSB:sysctl_pkg::SEC_LSB];
    assign opc2 = i_instr[sysctl_pkg::OPC2_MSB:sysctl_pkg::OPC2_LSB];
    assign take = i_xfer_valid && (state_r == sysctl_pkg::ST_IDLE);

    // trap and access decisions for the offered word
    always_comb begin
        trap_nxt = i_cond_pass && for_sysctl &&
                   (is_data_op || is_ldst || (is_xfer && !i_privileged));
        acc_nxt  = i_cond_pass && for_sysctl && is_xfer && i_privileged;
    end

    // sub selection and side from the secondary fields
    always_comb begin
        sub_nxt  = sysctl_pkg::NIB_RST;
        side_nxt = 1'b0;
        case (prim)
            sysctl_pkg::REG_ID: begin
                // opcode2 picks id, cache type or tcm size
                if (opc2 == sysctl_pkg::OPC2_CACHETYPE) begin
                    sub_nxt = sysctl_pkg::SUB_CACHETYPE;
                end else if (opc2 == sysctl_pkg::OPC2_TCMSIZE) begin
                    sub_nxt = sysctl_pkg::SUB_TCMSIZE;
                end else begin
                    sub_nxt = sysctl_pkg::SUB_ID;
                end
            end
            sysctl_pkg::REG_CACHECFG, sysctl_pkg::REG_ACCPERM: begin
                side_nxt = opc2[0];
            end
            sysctl_pkg::REG_PROT, sysctl_pkg::REG_CACHEOP: begin
                // region number or cache operation lives in the secondary field
                sub_nxt = sec;
            end
            sysctl_pkg::REG_LOCKTCM: begin
                // secondary field picks lockdown or tcm region, opcode2 the side
                sub_nxt  = sec;
                side_nxt = opc2[0];
            end
            sysctl_pkg::REG_TEST: begin
                // test registers split on opcode2 alone
                sub_nxt = {1'b0, opc2};
            end
            default: begin
                sub_nxt  = sysctl_pkg::NIB_RST;
                side_nxt = 1'b0;
            end
        endcase
    end

    // which held numbers may be read or written
    always_comb begin
        readable = 1'b0;
        writable = 1'b0;
        case (reg_num_r)
            sysctl_pkg::REG_ID: begin
                readable = 1'b1;
            end
            sysctl_pkg::REG_CACHEOP: begin
                writable = 1'b1;
            end
            sysctl_pkg::REG_CTRL, sysctl_pkg::REG_CACHECFG, sysctl_pkg::REG_WBUF,
            sysctl_pkg::REG_ACCPERM, sysctl_pkg::REG_PROT, sysctl_pkg::REG_LOCKTCM,
            sysctl_pkg::REG_TRACEPID, sysctl_pkg::REG_TEST: begin
                readable = 1'b1;
                writable = 1'b1;
            end
            default: begin
                readable = 1'b0;
                writable = 1'b0;
            end
        endcase
    end

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sysctl_pkg::ST_IDLE: begin
                if (take) begin
                    state_nxt = sysctl_pkg::ST_ACCESS;
                end
            end
            sysctl_pkg::ST_ACCESS: begin
                // only a legal read needs the answer cycle
                if (acc_r && read_r) begin
                    state_nxt = sysctl_pkg::ST_RESP;
                end else begin
                    state_nxt = sysctl_pkg::ST_IDLE;
                end
            end
            sysctl_pkg::ST_RESP: begin
                state_nxt = sysctl_pkg::ST_IDLE;
            end
            // any stray code recovers to idle
            default: begin
                state_nxt = sysctl_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= sysctl_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // decisions captured with the word
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trap_r <= 1'b0;
            acc_r  <= 1'b0;
            read_r <= 1'b0;
        end else if (take) begin
            trap_r <= trap_nxt;
            acc_r  <= acc_nxt;
            read_r <= is_read;
        end
    end

    // selection fields held for the register owners
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reg_num_r <= sysctl_pkg::NIB_RST;
            sub_r     <= sysctl_pkg::NIB_RST;
            opc2_r    <= 3'h0;
            sec_r     <= sysctl_pkg::NIB_RST;
            side_r    <= 1'b0;
            wdata_r   <= sysctl_pkg::WORD_RST;
        end else if (take) begin
            reg_num_r <= prim;
            sub_r     <= sub_nxt;
            opc2_r    <= opc2;
            sec_r     <= sec;
            side_r    <= side_nxt;
            wdata_r   <= i_wdata;
        end
    end

    // read result capture
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data_r <= sysctl_pkg::WORD_RST;
        end else if ((state_r == sysctl_pkg::ST_ACCESS) && acc_r && read_r) begin
            // a read of a write-only number is not forwarded
            rd_data_r <= readable ? i_tgt_rdata : sysctl_pkg::WORD_RST;
        end
    end

    // abort writeback undo, one cycle after the abort
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            base_restore_r <= 1'b0;
        end else begin
            base_restore_r <= i_data_abort && i_mem_access;
        end
    end

    // strobes only in the access cycle; a write to read-only is dropped
    always_comb begin
        o_rd_strobe  = (state_r == sysctl_pkg::ST_ACCESS) && acc_r && read_r && readable;
        o_wr_strobe  = (state_r == sysctl_pkg::ST_ACCESS) && acc_r && !read_r && writable;
        o_undef_trap = (state_r == sysctl_pkg::ST_ACCESS) && trap_r;
        o_xfer_done  = ((state_r == sysctl_pkg::ST_ACCESS) && !(acc_r && read_r))
                       || (state_r == sysctl_pkg::ST_RESP);
        o_rd_valid   = (state_r == sysctl_pkg::ST_RESP);
        o_xfer_ready = (state_r == sysctl_pkg::ST_IDLE);
    end

    assign o_reg_num      = reg_num_r;
    assign o_sub_sel      = sub_r;
    assign o_opc2         = opc2_r;
    assign o_sec_field    = sec_r;
    assign o_side_instr   = side_r;
    assign o_wdata        = wdata_r;
    assign o_rd_data      = rd_data_r;
    assign o_base_restore = base_restore_r;

endmodule : sysctl_coproc_access_decode

// file: rtl/sysctl_instr_classify.sv
`timescale 1ns/100ps

// sorts one coprocessor instruction word into its kind
module sysctl_instr_classify (
    input  wire logic [31:0] i_instr,      // instruction word
    output logic             o_for_sysctl, // aimed at the system control unit
    output logic             o_is_xfer,    // register read or write transfer
    output logic             o_is_read,    // transfer direction is read
    output logic             o_is_data_op, // coprocessor data operation
    output logic             o_is_ldst     // coprocessor load or store
);

    logic class_coproc; // coprocessor op or transfer class
    logic class_ldst;   // coprocessor memory class

    // decode of the class and kind bits
    always_comb begin
        class_coproc = (i_instr[sysctl_pkg::CLASS_MSB:sysctl_pkg::CLASS_LSB]
                        == sysctl_pkg::CLASS_COPROC);
        class_ldst   = (i_instr[sysctl_pkg::LDST_MSB:sysctl_pkg::LDST_LSB]
                        == sysctl_pkg::CLASS_LDST);
        o_for_sysctl = (i_instr[sysctl_pkg::CPNUM_MSB:sysctl_pkg::CPNUM_LSB]
                        == sysctl_pkg::SYSCTL_CPNUM) && (class_coproc || class_ldst);
        o_is_xfer    = class_coproc && i_instr[sysctl_pkg::XFER_BIT];
        o_is_data_op = class_coproc && !i_instr[sysctl_pkg::XFER_BIT];
        o_is_ldst    = class_ldst;
        o_is_read    = o_is_xfer && i_instr[sysctl_pkg::DIR_BIT];
    end

endmodule : sysctl_instr_classify

// file: rtl/sysctl_pkg.sv
package sysctl_pkg;

    // instruction field positions
    localparam int COND_MSB     = 31;
    localparam int COND_LSB     = 28;
    localparam int CLASS_MSB    = 27;
    localparam int CLASS_LSB    = 24;
    localparam int LDST_MSB     = 27;
    localparam int LDST_LSB     = 25;
    localparam int OPC1_MSB     = 23;
    localparam int OPC1_LSB     = 21;
    localparam int DIR_BIT      = 20;
    localparam int PRIM_MSB     = 19;
    localparam int PRIM_LSB     = 16;
    localparam int CPNUM_MSB    = 11;
    localparam int CPNUM_LSB    = 8;
    localparam int OPC2_MSB     = 7;
    localparam int OPC2_LSB     = 5;
    localparam int XFER_BIT     = 4;
    localparam int SEC_MSB      = 3;
    localparam int SEC_LSB      = 0;

    // class codes and the coprocessor number answered here
    localparam logic [3:0] CLASS_COPROC = 4'he;
    localparam logic [2:0] CLASS_LDST   = 3'h6;
    localparam logic [3:0] SYSCTL_CPNUM = 4'hf;

    // register numbers
    localparam logic [3:0] REG_ID       = 4'h0;
    localparam logic [3:0] REG_CTRL     = 4'h1;
    localparam logic [3:0] REG_CACHECFG = 4'h2;
    localparam logic [3:0] REG_WBUF     = 4'h3;
    localparam logic [3:0] REG_RSV4     = 4'h4;
    localparam logic [3:0] REG_ACCPERM  = 4'h5;
    localparam logic [3:0] REG_PROT     = 4'h6;
    localparam logic [3:0] REG_CACHEOP  = 4'h7;
    localparam logic [3:0] REG_RSV8     = 4'h8;
    localparam logic [3:0] REG_LOCKTCM  = 4'h9;
    localparam logic [3:0] REG_RSV10    = 4'ha;
    localparam logic [3:0] REG_RSV11    = 4'hb;
    localparam logic [3:0] REG_RSV12    = 4'hc;
    localparam logic [3:0] REG_TRACEPID = 4'hd;
    localparam logic [3:0] REG_RSV14    = 4'he;
    localparam logic [3:0] REG_TEST     = 4'hf;

    // sub selection codes for register 0
    localparam logic [2:0] OPC2_CACHETYPE = 3'h1;
    localparam logic [2:0] OPC2_TCMSIZE   = 3'h2;
    localparam logic [3:0] SUB_ID         = 4'h0;
    localparam logic [3:0] SUB_CACHETYPE  = 4'h1;
    localparam logic [3:0] SUB_TCMSIZE    = 4'h2;

    // reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [3:0]  NIB_RST  = 4'h0;

    // transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_RESP   = 3'b100
    } xfer_state_t;

endpackage : sysctl_pkg

// file: verif/sysctl_props.sv
`timescale 1ns/100ps

// watches the decoder ports; each check but AST_TRAP_CLEAN and AST_RSV_ZERO ties an answer to its request
module sysctl_props (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_xfer_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_cond_pass,
    input  wire logic        i_privileged,
    input  wire logic [31:0] i_tgt_rdata,
    input  wire logic        i_data_abort,
    input  wire logic        i_mem_access,
    input  wire logic        o_xfer_ready,
    input  wire logic        o_rd_strobe,
    input  wire logic        o_wr_strobe,
    input  wire logic [3:0]  o_reg_num,
    input  wire logic [3:0]  o_sub_sel,
    input  wire logic        o_side_instr,
    input  wire logic [31:0] o_rd_data,
    input  wire logic        o_rd_valid,
    input  wire logic        o_undef_trap,
    input  wire logic        o_xfer_done,
    input  wire logic        o_base_restore
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // word taken at this edge
    wire logic take = i_xfer_valid && o_xfer_ready;
    // taken, condition passed, aimed at this unit
    wire logic hit  = take && i_cond_pass && i_instr[11:8] == 4'hf;
    // register transfer encoding
    wire logic xfr  = i_instr[27:24] == 4'he && i_instr[4];

    AST_TRAP_CLEAN: assert property (
        o_undef_trap |-> !o_wr_strobe && !o_rd_strobe && o_xfer_done)
        else $error("trap came with a strobe or without done");
    AST_USER_TRAP: assert property (
        hit && xfr && !i_privileged |=> o_undef_trap)
        else $error("unprivileged transfer not trapped");
    AST_DATAOP_TRAP: assert property (
        hit && i_instr[27:24] == 4'he && !i_instr[4] |=> o_undef_trap)
        else $error("data operation not trapped");
    AST_COND_FAIL: assert property (
        take && !i_cond_pass |=> !o_undef_trap && !o_wr_strobe && !o_rd_strobe && o_xfer_done)
        else $error("failed condition still acted");
    AST_REG_NUM: assert property (
        take |=> o_reg_num == $past(i_instr[19:16]))
        else $error("register number not from primary field");
    AST_SIDE_SEL: assert property (
        take && i_instr[19:16] inside {4'h2, 4'h5, 4'h9} |=> o_side_instr == $past(i_instr[5]))
        else $error("copy side wrong");
    AST_SUB15: assert property (
        take && i_instr[19:16] == 4'hf |=> o_sub_sel == {1'b0, $past(i_instr[7:5])})
        else $error("sub selection of number 15 wrong");
    AST_READ_SEQ: assert property (
        hit && xfr && i_privileged && i_instr[20] && i_instr[19:16] == 4'h1
        |=> o_rd_strobe ##1 (o_rd_valid && o_xfer_done))
        else $error("privileged read did not complete in two cycles");
    AST_READ_DATA: assert property (
        o_rd_strobe |=> o_rd_data == $past(i_tgt_rdata))
        else $error("read result differs from owner answer");
    AST_RSV_ZERO: assert property (
        o_rd_valid && o_reg_num inside {4'h4, 4'h8, 4'ha, 4'hb, 4'hc, 4'he} |-> o_rd_data == 32'h0)
        else $error("reserved number read not zero");
    AST_RESTORE: assert property (
        i_data_abort && i_mem_access |=> o_base_restore)
        else $error("base restore missing");

    // main scenarios reached
    COV_WRITE: cover property (o_wr_strobe);
    COV_READ: cover property (o_rd_strobe ##1 o_rd_valid);
    COV_TRAP: cover property (o_undef_trap);
endmodule : sysctl_props

bind sysctl_coproc_access_decode sysctl_props u_props (.*);

// file: verif/sysctl_reg_owner.sv
`timescale 1ns/100ps

// stands in for the register owners behind the decoder
module sysctl_reg_owner (
    input  wire logic        i_ref_clk,   // core clock
    input  wire logic        i_rd_strobe, // read of selected register
    input  wire logic [3:0]  i_reg_num,   // selected number
    input  wire logic [3:0]  i_sub_sel,   // selected sub register
    output logic      [31:0] o_rdata      // combinational answer
);
    logic flip_r = 1'b0; // idle pattern phase

    // idle value changes every cycle so a stale capture cannot pass
    always_ff @(posedge i_ref_clk) begin
        flip_r <= ~flip_r;
    end

    // answer carries the selection, so a misrouted read shows
    always_comb begin
        o_rdata = i_rd_strobe ? {24'hc0ffee, i_sub_sel, i_reg_num} : {16{flip_r, ~flip_r}};
    end
endmodule : sysctl_reg_owner

// file: verif/tb_top.sv
`timescale 1ns/100ps

// offers transfers to the decoder and compares every answer
module tb_top;
    typedef struct {
        logic [31:0] ins;  // instruction word
        logic        priv; // privileged mode
        logic        cond; // condition passed
        logic [2:0]  act;  // trap, write, read strobes
        logic        rv;   // read result shown
        logic [3:0]  sub;  // sub selection
        logic        side; // instruction copy
    } row_t;
    logic        i_ref_clk;
    logic        i_rst_n;
    logic        i_xfer_valid;
    logic [31:0] i_instr;
    logic        i_cond_pass;
    logic        i_privileged;
    logic [31:0] i_wdata;
    logic [31:0] i_tgt_rdata;
    logic        i_data_abort;
    logic        i_mem_access;
    logic        o_xfer_ready, o_rd_strobe, o_wr_strobe, o_side_instr;
    logic        o_rd_valid, o_undef_trap, o_xfer_done, o_base_restore;
    logic [3:0]  o_reg_num, o_sub_sel, o_sec_field;
    logic [2:0]  o_opc2;
    logic [31:0] o_wdata, o_rd_data;
    int          n_errors = 0;   // mismatches
    int          num_checks = 0; // comparisons
    logic [2:0]  got_act;        // strobes in access cycle
    logic [31:0] got_done;       // done pulses seen
    logic        got_rv;         // read result seen
    row_t        rows[23];       // ordinary cases

    sysctl_coproc_access_decode dut (.*);
    sysctl_reg_owner owner (
        .i_ref_clk   (i_ref_clk),
        .i_rd_strobe (o_rd_strobe),
        .i_reg_num   (o_reg_num),
        .i_sub_sel   (o_sub_sel),
        .o_rdata     (i_tgt_rdata)
    );

    // core clock
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    function automatic logic [31:0] xf(logic rd, logic [3:0] primary_reg_field, logic [3:0] secondary_reg_field, logic [2:0] op2);
        return {4'he, 4'he, 3'h0, rd, primary_reg_field, 4'h3, 4'hf, op2, 1'b1, secondary_reg_field};
    endfunction : xf

    // counts and reports one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // prints counts and verdict, ends the run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // one transfer: offer on ready, watch access and answer cycles
    task automatic run(input logic [31:0] ins, input logic pv, input logic cd);
        int k;
        k = 0;
        while (o_xfer_ready !== 1'b1 && k < 8) begin
            @(negedge i_ref_clk);
            k++;
        end
        if (o_xfer_ready !== 1'b1) begin
            n_errors++;
            stop_test();
        end
        i_xfer_valid = 1'b1;
        i_instr = ins;
        i_privileged = pv;
        i_cond_pass = cd;
        i_wdata = ~ins;
        @(negedge i_ref_clk);
        i_xfer_valid = 1'b0;
        got_act = {o_undef_trap, o_wr_strobe, o_rd_strobe};
        got_done = 32'(o_xfer_done);
        got_rv = o_rd_valid;
        @(negedge i_ref_clk);
        got_done = got_done + 32'(o_xfer_done);
        got_rv = got_rv | o_rd_valid;
        @(negedge i_ref_clk);
    endtask : run

    // main sequence
    initial begin
        i_rst_n = 1'b0;
        i_xfer_valid = 1'b0;
        i_instr = 32'h0;
        i_cond_pass = 1'b0;
        i_privileged = 1'b0;
        i_wdata = 32'h0;
        i_data_abort = 1'b0;
        i_mem_access = 1'b0;
        rows[0] = '{xf(0, 4'h1, 4'h0, 3'h0), 1, 1, 3'b010, 0, 4'h0, 0};
        rows[1] = '{xf(1, 4'h1, 4'h0, 3'h0), 1, 1, 3'b001, 1, 4'h0, 0};
        rows[2] = '{xf(1, 4'h0, 4'h0, 3'h1), 1, 1, 3'b001, 1, 4'h1, 0};
        rows[3] = '{xf(1, 4'h0, 4'h0, 3'h2), 1, 1, 3'b001, 1, 4'h2, 0};
        rows[4] = '{xf(1, 4'h0, 4'h0, 3'h5), 1, 1, 3'b001, 1, 4'h0, 0};
        rows[5] = '{xf(0, 4'h2, 4'h0, 3'h1), 1, 1, 3'b010, 0, 4'h0, 1};
        rows[6] = '{xf(0, 4'h5, 4'h0, 3'h0), 1, 1, 3'b010, 0, 4'h0, 0};
        rows[7] = '{xf(0, 4'h9, 4'h1, 3'h1), 1, 1, 3'b010, 0, 4'h1, 1};
        rows[8] = '{xf(0, 4'h6, 4'h3, 3'h0), 1, 1, 3'b010, 0, 4'h3, 0};
        rows[9] = '{xf(0, 4'hf, 4'h0, 3'h3), 1, 1, 3'b010, 0, 4'h3, 0};
        rows[10] = '{xf(0, 4'h7, 4'h5, 3'h0), 1, 1, 3'b010, 0, 4'h5, 0};
        rows[11] = '{xf(1, 4'h7, 4'h0, 3'h0), 1, 1, 3'b000, 1, 4'h0, 0};
        rows[12] = '{xf(1, 4'h4, 4'h0, 3'h0), 1, 1, 3'b000, 1, 4'h0, 0};
        rows[13] = '{xf(0, 4'hc, 4'h0, 3'h0), 1, 1, 3'b000, 0, 4'h0, 0};
        rows[14] = '{xf(0, 4'h0, 4'h0, 3'h0), 1, 1, 3'b000, 0, 4'h0, 0};
        rows[15] = '{xf(1, 4'h1, 4'h0, 3'h0), 0, 1, 3'b100, 0, 4'h0, 0};
        rows[16] = '{32'hee01_0f00, 1, 1, 3'b100, 0, 4'h0, 0};
        rows[17] = '{32'hed81_0f00, 1, 1, 3'b100, 0, 4'h0, 0};
        rows[18] = '{xf(0, 4'h1, 4'h0, 3'h0), 1, 0, 3'b000, 0, 4'h0, 0};
        rows[19] = '{32'hee01_0f00, 1, 0, 3'b000, 0, 4'h0, 0};
        rows[20] = '{xf(0, 4'h1, 4'h0, 3'h0) ^ 32'h100, 1, 1, 3'b000, 0, 4'h0, 0};
        rows[21] = '{xf(1, 4'hd, 4'h0, 3'h0), 1, 1, 3'b001, 1, 4'h0, 0};
        rows[22] = '{xf(0, 4'h1, 4'h0, 3'h0), 0, 1, 3'b100, 0, 4'h0, 0};
        repeat (2) @(negedge i_ref_clk);
        chk(32'({o_xfer_ready, o_xfer_done, o_undef_trap}), 32'h4, "reset idle");
        i_rst_n = 1'b1;
        for (int i = 0; i < 23; i++) begin
            run(rows[i].ins, rows[i].priv, rows[i].cond);
            chk(32'(got_act), 32'(rows[i].act), "strobes");
            chk(got_done, 32'h1, "done count");
            chk(32'(got_rv), 32'(rows[i].rv), "read shown");
            if (rows[i].act[1:0] != 2'b00) begin
                chk(32'(o_reg_num), 32'(rows[i].ins[19:16]), "number");
                chk(32'(o_sub_sel), 32'(rows[i].sub), "sub");
                chk(32'(o_side_instr), 32'(rows[i].side), "side");
                chk(32'(o_opc2), 32'(rows[i].ins[7:5]), "opc2 field");
                chk(32'(o_sec_field), 32'(rows[i].ins[3:0]), "secondary field");
            end
            if (rows[i].act[1]) chk(o_wdata, ~rows[i].ins, "wdata");
            if (rows[i].rv) chk(o_rd_data, rows[i].act[0] ?
                {24'hc0ffee, rows[i].sub, rows[i].ins[19:16]} : 32'h0, "rdata");
            $display("row %0d done", i);
        end
        i_data_abort = 1'b1;
        i_mem_access = 1'b1;
        @(negedge i_ref_clk);
        i_data_abort = 1'b0;
        i_mem_access = 1'b0;
        chk(32'(o_base_restore), 32'h1, "restore");
        @(negedge i_ref_clk);
        i_data_abort = 1'b1;
        chk(32'(o_base_restore), 32'h0, "restore pulse");
        @(negedge i_ref_clk);
        i_data_abort = 1'b0;
        chk(32'(o_base_restore), 32'h0, "unqualified");
        $display("abort test done");
        // reset in mid transfer clears held state
        run(rows[1].ins, 1'b1, 1'b1);
        i_xfer_valid = 1'b1;
        i_instr = rows[7].ins;
        @(negedge i_ref_clk);
        i_rst_n = 1'b0;
        i_xfer_valid = 1'b0;
        @(negedge i_ref_clk);
        chk(o_rd_data, 32'h0, "reset data");
        chk(32'({o_xfer_ready, o_wr_strobe, o_reg_num}), 32'h20, "reset ctl");
        i_rst_n = 1'b1;
        run(rows[0].ins, 1'b1, 1'b1);
        chk(32'(got_act), 32'h2, "recovery");
        $display("mid reset test done");
        stop_test();
    end
endmodule : tb_top
